// ---- logic/ccc_cfg.svh ----
// Offsets, field positions, reset values and timing figures of the counter core
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH

`define CCC_ADDR_OFFSET 7'h73
`define CCC_ADDR_TEMP_CLR 7'h74
`define CCC_ADDR_MODE 7'h75
`define CCC_ADDR_CTC_LO 7'h76
`define CCC_ADDR_CTC_HI 7'h77
`define CCC_ADDR_DTC_LO 7'h78
`define CCC_ADDR_DTC_HI 7'h79
`define CCC_ADDR_SCR_LO 7'h7A
`define CCC_ADDR_SCR_HI 7'h7B
`define CCC_ADDR_CCR_LO 7'h7C
`define CCC_ADDR_CCR_HI 7'h7D
`define CCC_ADDR_DCR_LO 7'h7E
`define CCC_ADDR_DCR_HI 7'h7F
`define CCC_RAM_WORDS 115

`define CCC_CMD_WRITE_BIT 7
`define CCC_MODE_RESET 8'h0E
`define CCC_WAKE_BASE_UV 3840

`define CCC_CLK_MHZ 40
`define CCC_UNIT_TICK_US 878900
`define CCC_UNIT_TICK_CYC (`CCC_UNIT_TICK_US * `CCC_CLK_MHZ)
`define CCC_LINE_LOW_MS 10000
`define CCC_LINE_LOW_CYC (`CCC_LINE_LOW_MS * 1000 * `CCC_CLK_MHZ)
`define CCC_TICKS_PER_HOUR 4096
`define CCC_SD_FAST_TICKS 256
`define CCC_SLOW_DIV 256

`endif

// ---- logic/ccc_pkg.sv ----
// Types shared by the coulomb counter core modules
package ccc_pkg;

    typedef struct packed {
        logic step;
        logic charge;
        logic [15:0] mag_uv;
    } ccc_sense_t;

    typedef struct packed {
        logic override_low;
        logic cal_en;
        logic chg_roll;
        logic dis_roll;
        logic [2:0] wake_code;
        logic zero;
    } ccc_mode_t;

    typedef struct packed {
        logic charge_duration_counter;
        logic discharge_duration_counter;
        logic self_discharge_accumulator;
        logic charge_accumulator;
        logic discharge_accumulator;
    } ccc_clr_t;

    typedef enum logic [1:0] {
        CCC_RX_CMD = 2'b01,
        CCC_RX_DATA = 2'b10
    } ccc_rx_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } ccc_tb_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic [7:0] sub;
        logic roll;
    } ccc_dur_state_t;

endpackage : ccc_pkg

// ---- logic/ccc_timebase.sv ----
// Unit tick generator: one pulse per 0.8789 s while running
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_timebase import ccc_pkg::*; #(
    parameter int PERIOD_CYC = `CCC_UNIT_TICK_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic run,
    output logic tick
);
    ccc_tb_state_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        // Phase is held while stopped so a sleep does not lose a partial period
        if (run) begin
            if (st_ff.cnt == 32'(PERIOD_CYC - 1)) begin
                nxt_st.cnt = '0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

    property p_tick_spacing;
        @(posedge core_clk) disable iff (!resetn)
        st_ff.tick |-> $past(st_ff.cnt) == 32'(PERIOD_CYC - 1) && st_ff.cnt == '0;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("unit tick off period"); // R02
endmodule : ccc_timebase

// ---- logic/ccc_dur_counter.sv ----
// 16-bit duration counter with rollover flag and slowed rate
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_dur_counter import ccc_pkg::*; (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic active,
    input wire logic clear,
    output logic [15:0] count,
    output logic roll
);
    ccc_dur_state_t st_ff, nxt_st;
    logic step;

    always_comb begin
        nxt_st = st_ff;
        step = 1'b0;
        if (tick && active) begin
            // Slowed mode takes one count per 256 ticks, i.e. per 225 s
            if (st_ff.roll) begin
                nxt_st.sub = st_ff.sub + 8'h01;
                step = st_ff.sub == 8'(`CCC_SLOW_DIV - 1); // R06
            end else begin
                step = 1'b1; // R02 R04
            end
        end
        if (clear) begin
            nxt_st = '0; // R16
        end else if (step) begin
            nxt_st.count = st_ff.count + 16'h0001;
            if (st_ff.count == 16'hFFFF) begin
                // A second wrap drops the flag again
                nxt_st.roll = ~st_ff.roll; // R05
                nxt_st.sub = '0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign count = st_ff.count;
    assign roll = st_ff.roll;

    property p_wrap_flag;
        @(posedge core_clk) disable iff (!resetn)
        (!clear && tick && active && !st_ff.roll && st_ff.count == 16'hFFFF)
            |=> st_ff.roll && st_ff.count == 16'h0000;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("rollover flag not set"); // R05

    property p_clear_default;
        @(posedge core_clk) disable iff (!resetn)
        clear |=> !st_ff.roll && st_ff.count == 16'h0000 && st_ff.sub == 8'h00;
    endproperty
    a_clear_default: assert property (p_clear_default) else $error("clear left flag"); // R16

    property p_slow_rate;
        @(posedge core_clk) disable iff (!resetn)
        (!clear && tick && active && st_ff.roll && st_ff.sub != 8'hFF)
            |=> $stable(st_ff.count);
    endproperty
    a_slow_rate: assert property (p_slow_rate) else $error("slow counter ran fast"); // R06
endmodule : ccc_dur_counter

// ---- logic/ccc_core.sv ----
// Coulomb counter core: accumulators, duration timers, sleep, calibration, register map
//
// Operation
// R01 - Discharge polarity steps discharge accumulator
// R02 - Discharge timer ticks every 0.8789 s
// R03 - Charge polarity steps charge accumulator
// R04 - Charge timer ticks; discharge timer idles
// R05 - Timer wrap sets flag, rate drops 256x; here a second wrap clears the flag again
// R06 - Flagged timer counts once per 225 s
// R07 - Above threshold, line high: run, wake low
// R08 - Below threshold, line low 10 s: sleep
// R09 - Self-discharge rate doubles per 10 degrees
// R10 - 3-bit temperature code, x1/8 to x16
// R11 - Offset register holds signed 8-bit offset
// R12 - Below threshold, wake pin released
// R13 - Reset loads mode register with 0Eh
// R14 - Threshold is 3.84 mV over code
// R15 - Clear bits zero pair, self-return
// R16 - Timer clear drops flag, default rate
// R17 - Calibration bit arms offset calibration
// R18 - One quiet hour latches offset, clears bit
// R19 - Top 13 bytes control, rest user storage
// R20 - Command byte: bit 7 write, 7-bit address
// R21 - Broken conditions restart calibration
// R22 - Override skips line-low need, self-clears
// R23 - Host clears accumulators before they wrap
// R24 - Mode bit 0 reads zero, high byte odd
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_core import ccc_pkg::*; #(
    parameter int UNIT_TICK_CYC = `CCC_UNIT_TICK_CYC,
    parameter int LINE_LOW_CYC = `CCC_LINE_LOW_CYC,
    parameter int CAL_TICKS = `CCC_TICKS_PER_HOUR,
    parameter int SD_FAST_TICKS = `CCC_SD_FAST_TICKS
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire ccc_sense_t sense,
    input wire logic [2:0] temperature_code,
    input wire logic single_wire_line,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic tx_valid_ff,
    output logic [7:0] tx_byte_ff,
    output logic wake_pull_low_ff,
    output logic asleep_ff
);
    typedef struct packed {
        logic [`CCC_RAM_WORDS-1:0][7:0] ram;
        logic [7:0] offset_value;
        ccc_mode_t mode;
        ccc_clr_t clr;
        logic [15:0] dacc;
        logic [15:0] cacc;
        logic [15:0] sacc;
        logic [15:0] sd_sub;
        logic [31:0] low_cnt;
        logic asleep;
        logic [15:0] cal_cnt;
        logic signed [15:0] cal_net;
        ccc_rx_t rx;
        logic [6:0] wr_addr;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic wake;
    } ccc_core_state_t;

    ccc_core_state_t st_ff, nxt_st;
    logic tick;
    logic above;
    logic low_reached;
    logic cal_ok;
    logic dur_run;
    logic [15:0] ctc_count;
    logic [15:0] dtc_count;
    logic ctc_roll;
    logic dtc_roll;

    // Code 0 is invalid; it gives a threshold no signal can exceed
    function automatic logic [15:0] wake_threshold_voltage(input logic [2:0] code);
        if (code == 3'h0) begin
            return 16'hFFFF;
        end
        return 16'(`CCC_WAKE_BASE_UV / int'(code)); // R14
    endfunction : wake_threshold_voltage

    // Ticks per self-discharge count: 256 at code 7 up to 32768 at code 0
    function automatic logic [15:0] sd_period(input logic [2:0] code);
        return 16'(SD_FAST_TICKS << (3'h7 - code)); // R09 R10
    endfunction : sd_period

    function automatic logic [7:0] read_reg(input ccc_core_state_t s, input logic [6:0] a,
                                            input logic [2:0] temp, input logic [15:0] charge_duration_counter,
                                            input logic [15:0] discharge_duration_counter, input logic cr,
                                            input logic dr);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            `CCC_ADDR_OFFSET: d = s.offset_value;
            `CCC_ADDR_TEMP_CLR: d = {temp, s.clr};
            `CCC_ADDR_MODE: d = {s.mode.override_low, s.mode.cal_en, cr, dr,
                                 s.mode.wake_code, 1'b0}; // R24
            `CCC_ADDR_CTC_LO: d = charge_duration_counter[7:0];
            `CCC_ADDR_CTC_HI: d = charge_duration_counter[15:8];
            `CCC_ADDR_DTC_LO: d = discharge_duration_counter[7:0];
            `CCC_ADDR_DTC_HI: d = discharge_duration_counter[15:8];
            `CCC_ADDR_SCR_LO: d = s.sacc[7:0];
            `CCC_ADDR_SCR_HI: d = s.sacc[15:8];
            `CCC_ADDR_CCR_LO: d = s.cacc[7:0];
            `CCC_ADDR_CCR_HI: d = s.cacc[15:8];
            `CCC_ADDR_DCR_LO: d = s.dacc[7:0];
            `CCC_ADDR_DCR_HI: d = s.dacc[15:8];
            default: d = s.ram[a]; // R19
        endcase
        return d;
    endfunction : read_reg

    assign above = sense.mag_uv > wake_threshold_voltage(st_ff.mode.wake_code);
    assign low_reached = st_ff.low_cnt == 32'(LINE_LOW_CYC);
    assign cal_ok = st_ff.mode.cal_en && !above
                    && (low_reached || st_ff.mode.override_low); // R17 R22
    assign dur_run = !st_ff.asleep && sense.mag_uv != 16'h0000;

    // Timebase keeps running through a calibration hour even while asleep
    ccc_timebase #(
        .PERIOD_CYC(UNIT_TICK_CYC)
    ) u_timebase (
        .core_clk(core_clk),
        .resetn(resetn),
        .run(!st_ff.asleep || cal_ok),
        .tick(tick)
    );

    ccc_dur_counter u_charge_duration_counter (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick(tick),
        .active(dur_run && sense.charge), // R04
        .clear(st_ff.clr.charge_duration_counter),
        .count(ctc_count),
        .roll(ctc_roll)
    );

    ccc_dur_counter u_discharge_duration_counter (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick(tick),
        .active(dur_run && !sense.charge), // R02
        .clear(st_ff.clr.discharge_duration_counter),
        .count(dtc_count),
        .roll(dtc_roll)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tx_valid = 1'b0;
        nxt_st.mode.chg_roll = ctc_roll;
        nxt_st.mode.dis_roll = dtc_roll;
        nxt_st.mode.zero = 1'b0;
        nxt_st.wake = above; // R07 R12

        // Line-low timer saturates at the sleep limit
        if (single_wire_line) begin
            nxt_st.low_cnt = '0;
        end else if (!low_reached) begin
            nxt_st.low_cnt = st_ff.low_cnt + 32'h1;
        end

        if (single_wire_line) begin
            nxt_st.asleep = 1'b0; // R08
        end else if (low_reached && !above) begin
            nxt_st.asleep = 1'b1; // R08
        end

        if (!st_ff.asleep && sense.step) begin
            if (sense.charge) begin
                nxt_st.cacc = st_ff.cacc + 16'h0001; // R03
            end else begin
                nxt_st.dacc = st_ff.dacc + 16'h0001; // R01
            end
        end

        if (!st_ff.asleep && tick) begin
            if (st_ff.sd_sub + 16'h0001 >= sd_period(temperature_code)) begin
                nxt_st.sd_sub = '0;
                nxt_st.sacc = st_ff.sacc + 16'h0001; // R09
            end else begin
                nxt_st.sd_sub = st_ff.sd_sub + 16'h0001;
            end
        end

        // Calibration integrates signed sense steps over one hour of ticks
        if (!cal_ok) begin
            nxt_st.cal_cnt = '0; // R21
            nxt_st.cal_net = '0;
        end else begin
            if (sense.step) begin
                nxt_st.cal_net = sense.charge ? st_ff.cal_net + 16'sd1
                                              : st_ff.cal_net - 16'sd1;
            end
            if (tick) begin
                if (st_ff.cal_cnt == 16'(CAL_TICKS - 1)) begin
                    // Saturate so a large offset keeps its sign
                    if (st_ff.cal_net > 16'sd127) begin
                        nxt_st.offset_value = 8'h7F; // R11
                    end else if (st_ff.cal_net < -16'sd128) begin
                        nxt_st.offset_value = 8'h80;
                    end else begin
                        nxt_st.offset_value = st_ff.cal_net[7:0];
                    end
                    nxt_st.mode.cal_en = 1'b0; // R18
                    nxt_st.mode.override_low = 1'b0; // R22
                    nxt_st.cal_cnt = '0;
                    nxt_st.cal_net = '0;
                end else begin
                    nxt_st.cal_cnt = st_ff.cal_cnt + 16'h0001;
                end
            end
        end

        // Pending clears act for one cycle then return to zero
        if (st_ff.clr.discharge_accumulator) begin
            nxt_st.dacc = '0; // R15
        end
        if (st_ff.clr.charge_accumulator) begin
            nxt_st.cacc = '0; // R15
        end
        if (st_ff.clr.self_discharge_accumulator) begin
            nxt_st.sacc = '0; // R15
            nxt_st.sd_sub = '0;
        end
        nxt_st.clr = '0; // R15

        // Register access only while the core is awake
        if (rx_valid && !st_ff.asleep) begin
            unique case (st_ff.rx)
                CCC_RX_CMD: begin
                    if (rx_byte[`CCC_CMD_WRITE_BIT]) begin
                        nxt_st.rx = CCC_RX_DATA; // R20
                        nxt_st.wr_addr = rx_byte[6:0];
                    end else begin
                        nxt_st.tx_valid = 1'b1; // R20
                        nxt_st.tx_byte = read_reg(st_ff, rx_byte[6:0], temperature_code,
                                                  ctc_count, dtc_count, ctc_roll, dtc_roll);
                    end
                end
                CCC_RX_DATA: begin
                    nxt_st.rx = CCC_RX_CMD;
                    unique case (st_ff.wr_addr)
                        `CCC_ADDR_OFFSET: nxt_st.offset_value = rx_byte; // R11
                        `CCC_ADDR_TEMP_CLR: nxt_st.clr = rx_byte[4:0]; // R15
                        `CCC_ADDR_MODE: begin
                            // Rollover flags stay hardware owned
                            nxt_st.mode.override_low = rx_byte[7];
                            nxt_st.mode.cal_en = rx_byte[6]; // R17
                            nxt_st.mode.wake_code = rx_byte[3:1];
                        end
                        `CCC_ADDR_CTC_LO, `CCC_ADDR_CTC_HI, `CCC_ADDR_DTC_LO,
                        `CCC_ADDR_DTC_HI, `CCC_ADDR_SCR_LO, `CCC_ADDR_SCR_HI,
                        `CCC_ADDR_CCR_LO, `CCC_ADDR_CCR_HI, `CCC_ADDR_DCR_LO,
                        `CCC_ADDR_DCR_HI: begin
                        end
                        default: nxt_st.ram[st_ff.wr_addr] = rx_byte; // R19
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.mode <= `CCC_MODE_RESET; // R13
            st_ff.rx <= CCC_RX_CMD;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tx_valid_ff = st_ff.tx_valid;
    assign tx_byte_ff = st_ff.tx_byte;
    assign wake_pull_low_ff = st_ff.wake;
    assign asleep_ff = st_ff.asleep;

    property p_discharge_step;
        @(posedge core_clk) disable iff (!resetn)
        (!st_ff.asleep && sense.step && !sense.charge && !st_ff.clr.discharge_accumulator)
            |=> st_ff.dacc == $past(st_ff.dacc) + 16'h0001;
    endproperty
    a_discharge_step: assert property (p_discharge_step) else $error("discharge missed"); // R01

    property p_charge_step;
        @(posedge core_clk) disable iff (!resetn)
        (!st_ff.asleep && sense.step && sense.charge && !st_ff.clr.charge_accumulator && !st_ff.clr.discharge_accumulator)
            |=> st_ff.cacc == $past(st_ff.cacc) + 16'h0001 && $stable(st_ff.dacc);
    endproperty
    a_charge_step: assert property (p_charge_step) else $error("charge missed"); // R03

    property p_wake_follows;
        @(posedge core_clk) disable iff (!resetn)
        above |=> wake_pull_low_ff;
    endproperty
    a_wake_follows: assert property (p_wake_follows) else $error("wake not driven"); // R07

    property p_wake_release;
        @(posedge core_clk) disable iff (!resetn)
        !above |=> !wake_pull_low_ff;
    endproperty
    a_wake_release: assert property (p_wake_release) else $error("wake not released"); // R12

    property p_enter_sleep;
        @(posedge core_clk) disable iff (!resetn)
        (low_reached && !above && !single_wire_line) |=> st_ff.asleep;
    endproperty
    a_enter_sleep: assert property (p_enter_sleep) else $error("sleep not entered"); // R08

    property p_sleep_frozen;
        @(posedge core_clk) disable iff (!resetn)
        (st_ff.asleep && !st_ff.clr.discharge_accumulator && !st_ff.clr.charge_accumulator) |=> $stable(st_ff.dacc)
            && $stable(st_ff.cacc);
    endproperty
    a_sleep_frozen: assert property (p_sleep_frozen) else $error("counted in sleep"); // R08

    property p_clear_pair;
        @(posedge core_clk) disable iff (!resetn)
        st_ff.clr.discharge_accumulator |=> st_ff.dacc == 16'h0000 && !st_ff.clr.discharge_accumulator;
    endproperty
    a_clear_pair: assert property (p_clear_pair) else $error("clear did not zero"); // R15

    property p_mode_bit0;
        @(posedge core_clk) disable iff (!resetn)
        (rx_valid && !st_ff.asleep && st_ff.rx == CCC_RX_CMD
            && rx_byte == {1'b0, `CCC_ADDR_MODE}) |=> tx_valid_ff && !tx_byte_ff[0];
    endproperty
    a_mode_bit0: assert property (p_mode_bit0) else $error("mode bit 0 set"); // R24

    property p_cal_done;
        @(posedge core_clk) disable iff (!resetn)
        (cal_ok && tick && st_ff.cal_cnt == 16'(CAL_TICKS - 1))
            |=> !st_ff.mode.cal_en && !st_ff.mode.override_low;
    endproperty
    a_cal_done: assert property (p_cal_done) else $error("calibration not closed"); // R18

    property p_cal_restart;
        @(posedge core_clk) disable iff (!resetn)
        !cal_ok |=> st_ff.cal_cnt == 16'h0000;
    endproperty
    a_cal_restart: assert property (p_cal_restart) else $error("calibration kept"); // R21
endmodule : ccc_core

// ---- testbench/ccc_host_model.sv ----
// Host controller model: sends command and data bytes, takes read answers
`timescale 1ns/1ps
module ccc_host_model import ccc_pkg::*; (
    input wire logic core_clk,
    input wire logic tx_valid_ff,
    input wire logic [7:0] tx_byte_ff,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic line_high
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        line_high = 1'b1;
    end
    task automatic set_line(input logic v);
        @(posedge core_clk);
        line_high <= v;
    endtask : set_line
    // Command and data go back to back, as the real host may
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_byte <= {1'b1, addr};
        @(posedge core_clk);
        rx_byte <= data;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~data;
    endtask : wr
    // Answer is a one-cycle pulse, so it is taken in the cycle it stands
    task automatic rd(input logic [6:0] addr, output logic [7:0] data, output logic seen);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_byte <= {1'b0, addr};
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_byte <= {1'b1, ~addr};
        #1;
        seen = tx_valid_ff;
        data = tx_byte_ff;
    endtask : rd
endmodule : ccc_host_model

// ---- testbench/ccc_core_bench.sv ----
// Self-checking bench for the coulomb counter core
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_core_bench import ccc_pkg::*;;
    localparam int TICK = 8;
    localparam int SDF = 2;
    logic core_clk = 1'b0;
    logic resetn;
    ccc_sense_t sense;
    logic [2:0] temp;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic line;
    logic tx_valid_ff;
    logic [7:0] tx_byte_ff;
    logic wake;
    logic asleep;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 27938;

    always #12.5 core_clk = ~core_clk;

    ccc_core #(.UNIT_TICK_CYC(TICK), .LINE_LOW_CYC(20), .CAL_TICKS(4),
        .SD_FAST_TICKS(SDF)) dut (
        .core_clk(core_clk), .resetn(resetn), .sense(sense), .temperature_code(temp),
        .single_wire_line(line), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_valid_ff(tx_valid_ff), .tx_byte_ff(tx_byte_ff),
        .wake_pull_low_ff(wake), .asleep_ff(asleep));

    ccc_host_model host (
        .core_clk(core_clk), .tx_valid_ff(tx_valid_ff), .tx_byte_ff(tx_byte_ff),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .line_high(line));

    task automatic report_and_stop();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [15:0] inr(input logic [15:0] v, input int lo, input int hi);
        return 16'(v >= lo && v <= hi);
    endfunction : inr

    // Code 0 never wakes
    function automatic logic [15:0] thr(input logic [2:0] c);
        return (c == 3'h0) ? 16'hFFFF : 16'(3840 / c);
    endfunction : thr

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic rd8(input logic [6:0] a, output logic [7:0] d);
        logic s;
        host.rd(a, d, s);
        chk(16'(s), 16'h1);
    endtask : rd8

    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd8(a, lo);
        rd8(a + 7'h1, hi);
        v = {hi, lo};
    endtask : rd16

    task automatic set_mag(input logic [15:0] m, input logic chg);
        @(posedge core_clk);
        sense.mag_uv <= m;
        sense.charge <= chg;
    endtask : set_mag

    // Random quanta over n cycles; k returns how many were sent
    task automatic steps(input int n, input logic chg, output int k);
        logic b;
        k = 0;
        repeat (n) begin
            @(posedge core_clk);
            b = 1'($random(seed));
            sense.step <= b;
            sense.charge <= chg;
            k += int'(b);
        end
        @(posedge core_clk);
        sense.step <= 1'b0;
    endtask : steps

    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        logic [7:0] d;
        logic [15:0] v;
        logic [15:0] keep;
        logic [7:0] mem [8];
        logic [6:0] ad [8];
        int n;
        int k;
        resetn = 1'b0;
        sense = '0;
        temp = 3'h3;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        cyc(1);
        chk(16'(wake), 16'h0);
        rd8(`CCC_ADDR_MODE, d);
        chk(16'(d), 16'h000E);
        for (int i = 0; i < 8; i++) begin
            ad[i] = (i == 7) ? 7'h72 : 7'(i * 14 + $unsigned($random(seed)) % 14);
            mem[i] = 8'($random(seed));
            host.wr(ad[i], mem[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd8(ad[i], d);
            chk(16'(d), 16'(mem[i]));
        end
        mem[0] = 8'($random(seed));
        host.wr(`CCC_ADDR_OFFSET, mem[0]);
        rd8(`CCC_ADDR_OFFSET, d);
        chk(16'(d), 16'(mem[0]));
        host.wr(`CCC_ADDR_DCR_HI, 8'hA5);
        rd8(`CCC_ADDR_DCR_HI, d);
        chk(16'(d), 16'h0000);
        // Override calibration with the line high, random charge quanta over six cycles inside
        host.wr(`CCC_ADDR_MODE, 8'hFF);
        rd8(`CCC_ADDR_MODE, d);
        chk(16'(d), 16'h00CE);
        steps(6, 1'b1, k);
        cyc(60);
        rd8(`CCC_ADDR_MODE, d);
        chk(16'(d), 16'h000E);
        rd8(`CCC_ADDR_OFFSET, d);
        chk(16'(d == 8'(k) || d == 8'(-k)), 16'h1);
        rd16(`CCC_ADDR_CCR_LO, v);
        chk(v, 16'(k));
        host.wr(`CCC_ADDR_TEMP_CLR, 8'h1F);
        rd8(`CCC_ADDR_TEMP_CLR, d);
        chk(16'(d), {8'h00, temp, 5'h00});
        rd16(`CCC_ADDR_CCR_LO, v);
        chk(v, 16'h0000);
        n = 1 + $unsigned($random(seed)) % 20;
        set_mag(16'(600 + $unsigned($random(seed)) % 3000), 1'b0);
        steps(n, 1'b0, k);
        cyc(79 - n);
        chk(16'(wake), 16'h1);
        set_mag(16'd0, 1'b0);
        cyc(2);
        chk(16'(wake), 16'h0);
        rd16(`CCC_ADDR_DCR_LO, v);
        chk(v, 16'(k));
        rd16(`CCC_ADDR_DTC_LO, keep);
        chk(inr(keep, 9, 11), 16'h1);
        rd16(`CCC_ADDR_CTC_LO, v);
        chk(v, 16'h0000);
        n = 1 + $unsigned($random(seed)) % 20;
        set_mag(16'(600 + $unsigned($random(seed)) % 3000), 1'b1);
        steps(n, 1'b1, k);
        cyc(79 - n);
        set_mag(16'd0, 1'b1);
        rd16(`CCC_ADDR_CCR_LO, v);
        chk(v, 16'(k));
        rd16(`CCC_ADDR_CTC_LO, v);
        chk(inr(v, 9, 11), 16'h1);
        rd16(`CCC_ADDR_DTC_LO, v);
        chk(v, keep);
        host.wr(`CCC_ADDR_TEMP_CLR, 8'h08);
        rd16(`CCC_ADDR_DTC_LO, v);
        chk(v, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            host.wr(`CCC_ADDR_MODE, {4'h0, 3'(c), 1'b0});
            set_mag(thr(3'(c)) + 16'(c != 0), 1'($random(seed)));
            cyc(2);
            chk(16'(wake), 16'(c != 0));
            set_mag(thr(3'(c)), 1'b0);
            cyc(2);
            chk(16'(wake), 16'h0);
        end
        set_mag(16'd0, 1'b0);
        host.wr(`CCC_ADDR_MODE, 8'h0E);
        // Four periods of self-discharge at every temperature band
        for (int t = 0; t < 8; t++) begin
            @(posedge core_clk);
            temp <= 3'(t);
            host.wr(`CCC_ADDR_TEMP_CLR, 8'h04);
            cyc(4 * TICK * (SDF << (7 - t)));
            rd16(`CCC_ADDR_SCR_LO, v);
            chk(inr(v, 3, 5), 16'h1);
            rd8(`CCC_ADDR_TEMP_CLR, d);
            chk(16'(d), {8'h00, 3'(t), 5'h00});
        end
        // Broken quiet period must restart calibration
        host.wr(`CCC_ADDR_MODE, 8'h4E);
        host.set_line(1'b0);
        cyc(40);
        chk(16'(asleep), 16'h1);
        host.set_line(1'b1);
        cyc(2);
        host.set_line(1'b0);
        cyc(40);
        host.set_line(1'b1);
        cyc(3);
        chk(16'(asleep), 16'h0);
        rd8(`CCC_ADDR_MODE, d);
        chk(16'(d), 16'h004E);
        host.set_line(1'b0);
        cyc(90);
        host.set_line(1'b1);
        cyc(3);
        rd8(`CCC_ADDR_MODE, d);
        chk(16'(d), 16'h000E);
        report_and_stop();
    end
endmodule : ccc_core_bench
